// ---- bench/issue_stage_model.sv ----
// Issue-stage model that drives instruction fields into the operand decoder
`timescale 1ns/100ps
`default_nettype none
module issue_stage_model (
    // Clock
    input  wire logic                           clock_i,
    // Requests from the scenario
    input  wire operand_decode_pkg::thread_ctrl_t thread_ctrl_i,
    input  wire operand_decode_pkg::bank_t        bank_i,
    input  wire operand_decode_pkg::imm_class_t   imm_class_i,
    input  wire logic                           dispatch_req_i,
    input  wire logic                           mode_req_i,
    // Fields towards the decoder
    output logic                                issue_valid_o,
    output logic                                message_dispatch_o,
    output logic                                addressing_mode_bit_o,
    output logic      [31:0]                    immediate_word_field_o,
    output logic      [63:0]                    immediate_quad_field_o
);
    import operand_decode_pkg::*;
    // Atomic never travels without a dispatch opcode
    assign message_dispatch_o = dispatch_req_i | (thread_ctrl_i == TC_ATOMIC);
    // Architectural operands are always encoded direct
    assign addressing_mode_bit_o = mode_req_i & (bank_i != BANK_ARCH);
    initial begin
        issue_valid_o = 1'b0;
        immediate_word_field_o = 32'h0;
        immediate_quad_field_o = 64'h0;
    end
    task automatic issue(input logic [63:0] value);
        @(posedge clock_i);
        issue_valid_o <= 1'b1;
        immediate_word_field_o <= (imm_class_i == IMM_WORD) ? {2{value[15:0]}} : value[31:0];
        immediate_quad_field_o <= value;
        @(posedge clock_i);
        issue_valid_o <= 1'b0;
        // Stale immediates must not be relied on after the issue cycle
        immediate_word_field_o <= ~immediate_word_field_o;
    endtask : issue
endmodule : issue_stage_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the operand field decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
    import operand_decode_pkg::*;
    logic clock_i, rstn_i, wr, rd, ivld, disp, dreq, mode, mreq, conv, frg, four, ovr;
    logic dv, ill, swok, hold, fsw;
    logic [7:0] addr, regn, swz;
    logic [15:0] wdat, rdat, oaddr, wmask;
    logic [1:0] srcs, strd;
    logic [4:0] subn;
    logic [9:0] ioff;
    logic [3:0] isel, wen;
    logic [2:0] strd_o;
    logic [30:0] mdesc, mdesc_o;
    logic [31:0] ip, uoff, joff, ruoff, rjoff, exd, exd_o, immw, utgt, jtgt;
    logic [63:0] immq, lsrc, imm_o;
    thread_ctrl_t tc;
    slot_t slot;
    bank_t bank, bank_o;
    imm_class_t cls;
    int num_errors = 0;
    int checks_done = 0;

    operand_field_decoder u_operand_field_decoder (.clock_i(clock_i), .rstn_i(rstn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .issue_valid_i(ivld), .thread_switch_control_i(tc), .message_dispatch_i(disp),
        .source_count_i(srcs), .converging_branch_i(conv), .offsets_from_reg_i(frg),
        .current_ip_i(ip), .update_pointer_offset_i(uoff), .jump_pointer_offset_i(joff),
        .reg_update_offset_i(ruoff), .reg_jump_offset_i(rjoff), .operand_slot_i(slot),
        .operand_bank_i(bank), .addressing_mode_bit_i(mode), .four_lane_aligned_mode_i(four),
        .reg_number_i(regn), .subreg_number_i(subn), .indirect_offset_field_i(ioff),
        .index_subregister_select_i(isel), .lane_write_enable_i(wen), .mask_override_bit_i(ovr),
        .lane_swizzle_select_i(swz), .row_element_stride_i(strd), .message_desc_i(mdesc),
        .extended_message_word_i(exd), .imm_class_i(cls), .immediate_word_field_i(immw),
        .immediate_quad_field_i(immq), .decode_valid_o(dv), .illegal_o(ill),
        .switch_allowed_o(swok), .hold_thread_o(hold), .force_switch_o(fsw),
        .update_target_o(utgt), .jump_target_o(jtgt), .operand_byte_addr_o(oaddr),
        .bank_o(bank_o), .lane_write_mask_o(wmask), .lane_source_index_o(lsrc),
        .stride_elements_o(strd_o), .message_desc_o(mdesc_o), .extended_message_o(exd_o),
        .immediate_o(imm_o));
    issue_stage_model u_issue_stage_model (.clock_i(clock_i), .thread_ctrl_i(tc),
        .bank_i(bank), .imm_class_i(cls), .dispatch_req_i(dreq), .mode_req_i(mreq),
        .issue_valid_o(ivld), .message_dispatch_o(disp), .addressing_mode_bit_o(mode),
        .immediate_word_field_o(immw), .immediate_quad_field_o(immq));

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] e);
        checks_done++;
        if (seen !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, seen);
        end
    endtask : check
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [15:0] e, input string what);
        @(posedge clock_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        check(what, rdat, e);
    endtask : reg_read
    // Status is sticky, so each look also clears it for the next scenario
    task automatic status_is(input logic [15:0] e);
        reg_read(8'h10, e, "status");
        reg_write(8'h10, 16'h001f);
    endtask : status_is
    task automatic run(input logic [63:0] value);
        u_issue_stage_model.issue(value);
        #1;
        check("decode_valid", dv, 1);
    endtask : run
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic thread_codes;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            tc <= thread_ctrl_t'(i);
            run(64'h0);
            check("switch_allowed", swok, i == 0);
            check("hold_thread", hold, i == 1);
            check("force_switch", fsw, i == 2);
            check("illegal", ill, i == 3);
        end
        status_is(16'h0001);
        @(posedge clock_i);
        tc <= TC_NORMAL;
    endtask : thread_codes
    task automatic addressing;
        reg_write(8'h0f, 16'h0100);
        @(posedge clock_i);
        mreq <= 1'b1;
        isel <= 4'hf;
        ioff <= 10'h3fc;
        run(64'h0);
        check("indirect addr", oaddr, 16'h00fc);
        @(posedge clock_i);
        four <= 1'b1;
        ioff <= 10'h3ff;
        run(64'h0);
        check("aligned addr", oaddr, 16'h00f0);
        @(posedge clock_i);
        srcs <= 2'd3;
        run(64'h0);
        check("three source addr", oaddr, 16'h0243);
        @(posedge clock_i);
        srcs <= 2'd1;
        mreq <= 1'b0;
    endtask : addressing
    task automatic lanes_and_strides;
        @(posedge clock_i);
        wen <= 4'ha;
        swz <= 8'hb6;
        run(64'h0);
        check("write mask", wmask, 16'haaaa);
        check("lane sources", lsrc, 64'hefde_ab9a_6756_2312);
        @(posedge clock_i);
        swz <= 8'h44;
        run(64'h0);
        check("pair sources", lsrc, 64'hdcdc_9898_5454_1010);
        @(posedge clock_i);
        ovr <= 1'b1;
        wen <= 4'h0;
        run(64'h0);
        check("override mask", wmask, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            strd <= 2'(i);
            run(64'h0);
            check("stride", strd_o, (i == 3) ? 4 : i);
        end
    endtask : lanes_and_strides
    task automatic branch_and_desc;
        @(posedge clock_i);
        dreq <= 1'b1;
        run(64'h0);
        check("update target", utgt, 32'h0000_0ff8);
        check("jump target", jtgt, 32'h0000_1020);
        check("descriptor", mdesc_o, 31'h5a5a_1234);
        check("extended descriptor", exd_o, 32'hcafe_0001);
        @(posedge clock_i);
        dreq <= 1'b0;
        conv <= 1'b1;
        frg <= 1'b1;
        run(64'h0);
        check("reg update target", utgt, 32'h0000_1004);
        check("reg jump target", jtgt, 32'h0000_0f00);
        check("descriptor off", mdesc_o, 0);
    endtask : branch_and_desc
    task automatic immediates;
        @(posedge clock_i);
        bank <= BANK_IMM;
        slot <= SLOT_SRC0;
        cls <= IMM_WORD;
        run(64'h0000_0000_0000_beef);
        check("word imm", imm_o, 64'h0000_0000_0000_beef);
        @(posedge clock_i);
        cls <= IMM_QWORD;
        run(64'h0123_4567_89ab_cdef);
        check("quad imm", imm_o, 64'h0123_4567_89ab_cdef);
        check("quad legal", ill, 0);
        @(posedge clock_i);
        cls <= IMM_BYTE;
        run(64'h0000_0000_0000_00a5);
        check("byte imm", ill, 1);
        @(posedge clock_i);
        cls <= IMM_QWORD;
        srcs <= 2'd2;
        slot <= SLOT_SRC1;
        run(64'h0123_4567_89ab_cdef);
        check("quad two source", ill, 1);
        status_is(16'h0008);
        @(posedge clock_i);
        bank <= BANK_RESERVED;
        cls <= IMM_DWORD;
        run(64'h0);
        check("reserved bank", ill, 1);
        status_is(16'h0002);
        @(posedge clock_i);
        bank <= BANK_ARCH;
        run(64'h0);
        check("arch on src1", ill, 1);
        @(posedge clock_i);
        slot <= SLOT_SRC0;
        run(64'h0);
        check("arch on src0", ill, 0);
        check("bank copy", bank_o, BANK_ARCH);
    endtask : immediates

    initial begin
        {rstn_i, wr, rd, dreq, mreq, conv, frg, four, ovr} = '0;
        {addr, wdat, wen, swz, strd, isel, ioff} = '0;
        tc = TC_NORMAL;
        slot = SLOT_DST;
        bank = BANK_GENERAL;
        cls = IMM_DWORD;
        srcs = 2'd1;
        {regn, subn, ip, uoff, joff} = {8'h12, 5'h03, 32'h1000, 32'hffff_fff8, 32'h20};
        {ruoff, rjoff, mdesc, exd} = {32'h4, 32'hffff_ff00, 31'h5a5a_1234, 32'hcafe_0001};
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        check("reset switch_allowed", swok, 1);
        reg_read(8'h11, 16'h0001, "control");
        reg_read(8'h20, 16'h0000, "unmapped");
        thread_codes();
        addressing();
        lanes_and_strides();
        branch_and_desc();
        immediates();
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// ---- pkg/operand_decode_pkg.sv ----
// Types shared by the operand decoder
package operand_decode_pkg;
    typedef enum logic [1:0] {
        TC_NORMAL   = 2'b00,
        TC_ATOMIC   = 2'b01,
        TC_SWITCH   = 2'b10,
        TC_RESERVED = 2'b11
    } thread_ctrl_t;
    typedef enum logic [1:0] {
        BANK_ARCH     = 2'b00,
        BANK_GENERAL  = 2'b01,
        BANK_RESERVED = 2'b10,
        BANK_IMM      = 2'b11
    } bank_t;
    typedef enum logic [1:0] {
        IMM_BYTE  = 2'b00,
        IMM_WORD  = 2'b01,
        IMM_DWORD = 2'b10,
        IMM_QWORD = 2'b11
    } imm_class_t;
    typedef enum logic [1:0] {
        SLOT_DST  = 2'b00,
        SLOT_SRC0 = 2'b01,
        SLOT_SRC1 = 2'b10,
        SLOT_SRC2 = 2'b11
    } slot_t;
endpackage : operand_decode_pkg

// ---- pkg/operand_decode_regs.svh ----
// Register offsets, field positions, reset values and encodings of the operand decoder
`ifndef OPERAND_DECODE_REGS_SVH
`define OPERAND_DECODE_REGS_SVH
`define OFS_SUBREG_BASE   8'h00
`define OFS_SUBREG_LAST   8'h0f
`define OFS_STATUS        8'h10
`define OFS_CONTROL       8'h11
`define CTRL_ATOMIC_CHECK 0
`define CTRL_RESET        16'h0001
`define SUBREG_RESET      16'h0000
`define ST_TC_RESERVED    0
`define ST_BANK_RESERVED  1
`define ST_ATOMIC_MISUSE  2
`define ST_IMM_ILLEGAL    3
`define ST_ARCH_INDIRECT  4
`define ST_WIDTH          5
`define FOUR_LANE_ALIGNED_MODE_ZERO_BITS 4
`endif

// ---- verilog/operand_field_decoder.sv ----
// Operand and control field decoder of an execution-unit instruction
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "operand_decode_regs.svh"

// Summary of operation
// - Normal thread control leaves arbitration free
// - Atomic blocks switch, same thread issues next
// - Switch forces another thread; 11b reserved
// - Update offset is signed byte offset
// - Indirect address is subregister plus signed immediate
// - Four-lane mode zeroes low immediate bits
// - Mode bit picks direct or indirect
// - Three-source instructions always decode direct
// - Sixteen 16-bit subregisters, 4-bit select
// - Write-enable bit j mod 4 gates lane in four-lane mode
// - Mask override enables all lanes
// - Swizzle holds 2-bit selector per lane
// - Selector picks source element 0 to 3
// - Dispatch extracts 31-bit and 32-bit descriptors
// - Stride code maps to 0,1,2,4 elements
// - Narrow immediates use low bits; no byte
// - 64-bit immediate only single-source, 64-bit type
// - Bank field selects arch, general, immediate
module operand_field_decoder #(
    parameter int LANES = 16
) (
    // Clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       rstn_i,
    // Register port
    input  wire logic [7:0]                 reg_addr_i,
    input  wire logic [15:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [15:0]                reg_rdata_o,
    // Instruction fields from issue
    input  wire logic                       issue_valid_i,
    input  wire operand_decode_pkg::thread_ctrl_t thread_switch_control_i,
    input  wire logic                       message_dispatch_i,
    input  wire logic [1:0]                 source_count_i,
    input  wire logic                       converging_branch_i,
    input  wire logic                       offsets_from_reg_i,
    input  wire logic [31:0]                current_ip_i,
    input  wire logic [31:0]                update_pointer_offset_i,
    input  wire logic [31:0]                jump_pointer_offset_i,
    input  wire logic [31:0]                reg_update_offset_i,
    input  wire logic [31:0]                reg_jump_offset_i,
    input  wire operand_decode_pkg::slot_t  operand_slot_i,
    input  wire operand_decode_pkg::bank_t  operand_bank_i,
    input  wire logic                       addressing_mode_bit_i,
    input  wire logic                       four_lane_aligned_mode_i,
    input  wire logic [7:0]                 reg_number_i,
    input  wire logic [4:0]                 subreg_number_i,
    input  wire logic [9:0]                 indirect_offset_field_i,
    input  wire logic [3:0]                 index_subregister_select_i,
    input  wire logic [3:0]                 lane_write_enable_i,
    input  wire logic                       mask_override_bit_i,
    input  wire logic [7:0]                 lane_swizzle_select_i,
    input  wire logic [1:0]                 row_element_stride_i,
    input  wire logic [30:0]                message_desc_i,
    input  wire logic [31:0]                extended_message_word_i,
    input  wire operand_decode_pkg::imm_class_t imm_class_i,
    input  wire logic [31:0]                immediate_word_field_i,
    input  wire logic [63:0]                immediate_quad_field_i,
    // Decoded results
    output logic                            decode_valid_o,
    output logic                            illegal_o,
    output logic                            switch_allowed_o,
    output logic                            hold_thread_o,
    output logic                            force_switch_o,
    output logic      [31:0]                update_target_o,
    output logic      [31:0]                jump_target_o,
    output logic      [15:0]                operand_byte_addr_o,
    output operand_decode_pkg::bank_t       bank_o,
    output logic      [LANES-1:0]           lane_write_mask_o,
    output logic      [4*LANES-1:0]         lane_source_index_o,
    output logic      [2:0]                 stride_elements_o,
    output logic      [30:0]                message_desc_o,
    output logic      [31:0]                extended_message_o,
    output logic      [63:0]                immediate_o
);
    import operand_decode_pkg::*;

    function automatic logic [2:0] stride_of(input logic [1:0] code);
        stride_of = (code == 2'b11) ? 3'd4 : {1'b0, code};
    endfunction : stride_of

    logic [15:0]          subreg [16];
    logic [15:0]          control;
    logic [`ST_WIDTH-1:0] status;

    // Register decode
    wire       hit_subreg = reg_addr_i <= `OFS_SUBREG_LAST;
    wire       hit_status = reg_addr_i == `OFS_STATUS;
    wire       hit_ctrl   = reg_addr_i == `OFS_CONTROL;
    wire [3:0] reg_index  = reg_addr_i[3:0];
    wire [15:0] next_rdata = hit_subreg ? subreg[reg_index]
                           : hit_status ? {{(16-`ST_WIDTH){1'b0}}, status}
                           : hit_ctrl   ? control : 16'h0000;

    // Thread control
    wire tc_normal = thread_switch_control_i == TC_NORMAL;
    wire tc_atomic = thread_switch_control_i == TC_ATOMIC;
    wire tc_switch = thread_switch_control_i == TC_SWITCH;

    // Branch offsets; converging branch may take both from a register
    wire        use_reg_off = converging_branch_i & offsets_from_reg_i;
    wire [31:0] uoff = use_reg_off ? reg_update_offset_i : update_pointer_offset_i;
    wire [31:0] joff = use_reg_off ? reg_jump_offset_i : jump_pointer_offset_i;
    wire [31:0] next_update = current_ip_i + uoff;
    wire [31:0] next_jump   = current_ip_i + joff;

    // Operand addressing
    wire three_src = source_count_i == 2'd3;
    wire indirect  = addressing_mode_bit_i & ~three_src;
    // Low bits are not encoded in four-lane mode
    wire [9:0]  imm_off = four_lane_aligned_mode_i
                        ? {indirect_offset_field_i[9:`FOUR_LANE_ALIGNED_MODE_ZERO_BITS],
                           {`FOUR_LANE_ALIGNED_MODE_ZERO_BITS{1'b0}}}
                        : indirect_offset_field_i;
    wire [15:0] ind_addr = subreg[index_subregister_select_i]
                         + {{6{imm_off[9]}}, imm_off};
    wire [15:0] dir_addr = {3'b000, reg_number_i, subreg_number_i};
    wire [15:0] next_addr = indirect ? ind_addr : dir_addr;

    // Lane write enables and swizzle
    logic [LANES-1:0]   next_mask;
    logic [4*LANES-1:0] next_swz;
    always_comb begin
        for (int j = 0; j < LANES; j++) begin
            next_mask[j] = mask_override_bit_i | lane_write_enable_i[j % 4];
            // Element index is group base plus selector
            next_swz[4*j +: 4] = 4'((j / 4) * 4)
                               + {2'b00, lane_swizzle_select_i[2*(j%4) +: 2]};
        end
    end

    // Immediate extraction without type conversion
    logic [63:0] next_imm;
    always_comb begin
        unique case (imm_class_i)
            IMM_BYTE:  next_imm = 64'h0;
            IMM_WORD:  next_imm = {48'h0, immediate_word_field_i[15:0]};
            IMM_DWORD: next_imm = {32'h0, immediate_word_field_i};
            IMM_QWORD: next_imm = immediate_quad_field_i;
        endcase
    end

    // Illegal causes
    wire is_src     = operand_slot_i != SLOT_DST;
    wire last_src   = is_src && ({1'b0, operand_slot_i} == {1'b0, source_count_i});
    wire bank_bad   = (operand_bank_i == BANK_RESERVED)
                    | (operand_bank_i == BANK_ARCH
                       && operand_slot_i != SLOT_DST && operand_slot_i != SLOT_SRC0)
                    | (operand_bank_i == BANK_IMM && !last_src);
    wire imm_used   = operand_bank_i == BANK_IMM;
    wire imm_bad    = imm_used && (imm_class_i == IMM_BYTE
                    || (imm_class_i == IMM_QWORD && source_count_i != 2'd1));
    wire atomic_bad = tc_atomic & ~message_dispatch_i
                    & control[`CTRL_ATOMIC_CHECK];
    wire arch_ind   = operand_bank_i == BANK_ARCH && indirect;
    logic [`ST_WIDTH-1:0] cause;
    always_comb begin
        cause = '0;
        cause[`ST_TC_RESERVED]   = thread_switch_control_i == TC_RESERVED;
        cause[`ST_BANK_RESERVED] = bank_bad;
        cause[`ST_ATOMIC_MISUSE] = atomic_bad;
        cause[`ST_IMM_ILLEGAL]   = imm_bad;
        cause[`ST_ARCH_INDIRECT] = arch_ind;
    end
    wire [`ST_WIDTH-1:0] set_bits = issue_valid_i ? cause : '0;
    wire [`ST_WIDTH-1:0] clr_bits = (reg_wr_i && hit_status) ? reg_wdata_i[`ST_WIDTH-1:0] : '0;
    // New cause wins over a write-one clear in the same cycle
    wire [`ST_WIDTH-1:0] next_status = (status & ~clr_bits) | set_bits;

    // Register file
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 16; i++) subreg[i] <= `SUBREG_RESET;
            control     <= `CTRL_RESET;
            status      <= '0;
            reg_rdata_o <= 16'h0000;
        end else begin
            if (reg_wr_i && hit_subreg) subreg[reg_index] <= reg_wdata_i;
            if (reg_wr_i && hit_ctrl) control <= reg_wdata_i;
            status      <= next_status;
            reg_rdata_o <= reg_rd_i ? next_rdata : 16'h0000;
        end
    end

    // Decode stage
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            decode_valid_o <= 1'b0;
            illegal_o      <= 1'b0;
        end else begin
            decode_valid_o <= issue_valid_i;
            illegal_o      <= issue_valid_i & (|cause);
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            switch_allowed_o    <= 1'b1;
            hold_thread_o       <= 1'b0;
            force_switch_o      <= 1'b0;
            update_target_o     <= 32'h0;
            jump_target_o       <= 32'h0;
            operand_byte_addr_o <= 16'h0;
            bank_o              <= BANK_GENERAL;
            lane_write_mask_o   <= '0;
            lane_source_index_o <= '0;
            stride_elements_o   <= 3'd0;
            message_desc_o      <= 31'h0;
            extended_message_o  <= 32'h0;
            immediate_o         <= 64'h0;
        end else if (issue_valid_i) begin
            switch_allowed_o    <= tc_normal;
            hold_thread_o       <= tc_atomic;
            force_switch_o      <= tc_switch;
            update_target_o     <= next_update;
            jump_target_o       <= next_jump;
            operand_byte_addr_o <= next_addr;
            bank_o              <= operand_bank_i;
            // Write mask only applies in four-lane mode; swizzle always applies
            lane_write_mask_o   <= four_lane_aligned_mode_i ? next_mask : '1;
            lane_source_index_o <= next_swz;
            stride_elements_o   <= stride_of(row_element_stride_i);
            message_desc_o      <= message_dispatch_i ? message_desc_i : 31'h0;
            extended_message_o  <= message_dispatch_i ? extended_message_word_i : 32'h0;
            immediate_o         <= imm_used ? next_imm : 64'h0;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    a_switch_forced: assert property (
        issue_valid_i && thread_switch_control_i == TC_SWITCH
        |=> force_switch_o && !switch_allowed_o && !hold_thread_o)
        else $error("switch code did not force a thread switch");
    a_atomic_holds: assert property (
        issue_valid_i && thread_switch_control_i == TC_ATOMIC
        |=> hold_thread_o && !switch_allowed_o ##1 (hold_thread_o || decode_valid_o))
        else $error("atomic code did not hold the thread");
    a_normal_free: assert property (
        issue_valid_i && thread_switch_control_i == TC_NORMAL
        |=> switch_allowed_o && !force_switch_o)
        else $error("normal code did not leave arbitration free");
    a_lane_gating: assert property (
        issue_valid_i && four_lane_aligned_mode_i && !mask_override_bit_i
        |=> lane_write_mask_o == {(LANES/4){$past(lane_write_enable_i)}})
        else $error("lane mask does not follow write enables");
    a_override_all: assert property (
        issue_valid_i && mask_override_bit_i |=> &lane_write_mask_o)
        else $error("mask override did not enable all lanes");
    a_stride_four: assert property (
        issue_valid_i && row_element_stride_i == 2'b11 |=> stride_elements_o == 3'd4)
        else $error("stride code 11b not mapped to four");
    a_reserved_flag: assert property (
        issue_valid_i && (thread_switch_control_i == TC_RESERVED
                          || operand_bank_i == BANK_RESERVED)
        |=> illegal_o ##1 status[`ST_TC_RESERVED] || status[`ST_BANK_RESERVED])
        else $error("reserved encoding not flagged");
    a_three_direct: assert property (
        issue_valid_i && source_count_i == 2'd3
        |=> operand_byte_addr_o == {3'b000, $past(reg_number_i), $past(subreg_number_i)})
        else $error("three-source operand not directly addressed");
    a_desc_ignored: assert property (
        issue_valid_i && !message_dispatch_i
        |=> message_desc_o == 31'h0 && extended_message_o == 32'h0)
        else $error("descriptor passed for non-dispatch opcode");
    a_byte_imm: assert property (
        issue_valid_i && operand_bank_i == BANK_IMM && imm_class_i == IMM_BYTE |=> illegal_o)
        else $error("byte immediate not flagged");

    c_indirect: cover property (issue_valid_i && indirect && four_lane_aligned_mode_i);
    c_atomic_send: cover property (issue_valid_i && tc_atomic && message_dispatch_i);
    c_qword_imm: cover property (issue_valid_i && imm_used && imm_class_i == IMM_QWORD
                                 && source_count_i == 2'd1);
endmodule : operand_field_decoder
`default_nettype wire
